//--- verilog/ats_delay_regs.vh
// constants for the transfer time-delay sequencer: map, fields, timing
`ifndef ATS_DELAY_REGS_VH
`define ATS_DELAY_REGS_VH

// clock and timebase
`define CLK_PERIOD_NS 4
`define TICK_PERIOD_NS 100000000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

// register byte addresses
`define ADR_CONFIG 8'h00
`define ADR_STATUS 8'h04

// config field positions, each selector is three bits wide
`define CFG_START_LSB 0
`define CFG_COOL_LSB 3
`define CFG_NE_LSB 6
`define CFG_EN_LSB 9
`define CFG_PAUSE_LSB 12
`define CFG_ELEV_LSB 15
`define CFG_POST_HOLD 18
`define CFG_WIDTH 19

// reset: start 3 s, cooldown 10 min, n-to-e 5 s, e-to-n 10 min,
// neutral pause 0, elevator 0, post-transfer hold off
`define CFG_RESET 19'h0071C

// delay tables in 0.1 s ticks, entry 0 in the low 16 bits
// 0, 0.5, 1, 2, 3, 4, 6, 10 s
`define TBL_SHORT 128'h0064_003C_0028_001E_0014_000A_0005_0000
// 0, 0.1, 5, 10, 15, 20, 25, 30 min
`define TBL_MINUTES 128'h4650_3A98_2EE0_2328_1770_0BB8_003C_0000
// 0, 1, 2, 3, 5, 30, 120, 300 s
`define TBL_LONG 128'h0BB8_04B0_012C_0032_001E_0014_000A_0000

`endif

//--- verilog/tick_divider.v
// one-cycle timebase enable derived from the system clock
`timescale 1ns/10ps
module tick_divider #(
  parameter CNT_W = 25,
  parameter TICK_CYCLES = 25000000
) (
  input wire i_clock,
  input wire i_rst_n,
  output reg o_tick
);
  localparam [CNT_W-1:0] LAST = TICK_CYCLES - 1;
  reg [CNT_W-1:0] count; // cycles since last tick

  // free-running divider, pulse on the last count
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= {CNT_W{1'b0}};
      o_tick <= 1'b0;
    end else if (count == LAST) begin
      count <= {CNT_W{1'b0}};
      o_tick <= 1'b1;
    end else begin
      count <= count + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule // tick_divider

//--- verilog/delay_timer.v
// one delay timer counting timebase ticks up to a limit
`timescale 1ns/10ps
module delay_timer #(
  parameter W = 16
) (
  input wire i_clock,
  input wire i_rst_n,
  input wire i_tick,
  input wire i_clear,
  input wire i_run,
  input wire i_force,
  input wire [W-1:0] i_limit,
  output reg o_active,
  output reg o_done
);
  reg [W-1:0] count; // ticks elapsed
  wire [W-1:0] count_inc = count + 1'b1;

  // clear wins; counting only while run is high and not yet expired;
  // a low run without clear simply holds the count
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= {W{1'b0}};
      o_active <= 1'b0;
      o_done <= 1'b0;
    end else if (i_clear) begin
      count <= {W{1'b0}};
      o_active <= 1'b0;
      o_done <= 1'b0;
    end else if (i_run && !o_done) begin
      o_active <= 1'b1;
      // zero limit expires on the very next edge
      if (i_force || i_limit == {W{1'b0}} ||
          (i_tick && count_inc >= i_limit)) begin
        o_done <= 1'b1;
      end
      if (i_tick) begin
        count <= count_inc;
      end
    end
  end
endmodule // delay_timer

//--- verilog/transfer_delay_seq.v
// transfer switch time-delay sequencer with wishbone registers
//
// Overview of operation
// - engine start timer begins on utility failure
// - start delay 0,0.5,1,2,3,4,6,10 s; 3 s
// - utility returns during start delay: clear, no start
// - start delay expiry de-energizes start relay
// - override expires start, n-to-e, e-to-n timers
// - cooldown after retransfer; minute table, default 10
// - cooldown expiry stops generator, clears timer
// - override does not touch cooldown timer
// - n-to-e starts on failure/test with generator
// - n-to-e 0,1,2,3,5,30,120,300 s; 5 s
// - generator loss clears n-to-e, restarts later
// - inhibits block starting n-to-e and e-to-n
// - e-to-n starts on utility return or test end
// - utility loss restarts e-to-n; generator loss expires
// - neutral pause before closing; 0 s default
// - source loss keeps pause; go to live source
// - elevator output then delay, live transfers only
// - elevator expiry issues command, output drops unless post hold
// - elevator delay long table, default 0 s
// - inhibits and override ignore elevator delay
// - post hold reruns elevator delay after transfer
// - stop generator by energizing start relay
`timescale 1ns/10ps
`include "ats_delay_regs.vh"
module transfer_delay_seq #(
  parameter TICK_CYCLES = `TICK_CYCLES,
  parameter TW = 16
) (
  input wire i_clock,
  input wire i_rst_n,
  // wishbone classic slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  // source sensors and switch position
  input wire i_utility_ok,
  input wire i_genset_ok,
  input wire i_at_utility,
  input wire i_at_genset,
  // operator and remote inputs
  input wire i_override_button,
  input wire i_override_input,
  input wire i_transfer_inhibit,
  input wire i_retransfer_inhibit,
  input wire i_test_active,
  // relay and actuator outputs
  output reg o_start_relay,
  output reg o_transfer_cmd,
  output reg o_retransfer_cmd,
  output reg o_elevator
);

  //////////////////////////////////////////////////////////////////////
  // timer indices and sequencer states

  localparam T_START = 0; // engine start
  localparam T_COOL = 1; // engine cooldown
  localparam T_NE = 2; // normal to emergency
  localparam T_EN = 3; // emergency to normal
  localparam T_PAUSE = 4; // neutral pause
  localparam T_ELEV = 5; // elevator
  localparam NT = 6;

  localparam [2:0] ST_NORMAL = 3'h0; // on utility
  localparam [2:0] ST_ELEV_PRE = 3'h1; // elevator warning
  localparam [2:0] ST_OPEN = 3'h2; // leaving the first source
  localparam [2:0] ST_PAUSE = 3'h3; // in neutral
  localparam [2:0] ST_CLOSE = 3'h4; // closing to the target
  localparam [2:0] ST_ELEV_POST = 3'h5; // elevator hold after transfer
  localparam [2:0] ST_GENSET = 3'h6; // on generator

  //////////////////////////////////////////////////////////////////////
  // registers and shared signals
  reg [`CFG_WIDTH-1:0] settings; // delay selectors and post hold
  reg [2:0] state; // sequencer state
  reg to_gen; // direction of the transfer under way
  reg live_xfer; // both sources up when the transfer began
  wire tick; // 0.1 s enable
  reg [NT-1:0] t_clear; // per-timer clear
  reg [NT-1:0] t_run; // per-timer run
  reg [NT-1:0] t_force; // per-timer forced expiry
  wire [NT*TW-1:0] t_limit; // per-timer limit in ticks
  wire [NT-1:0] t_active; // timer has begun
  wire [NT-1:0] t_done; // timer expired

  wire override = i_override_button | i_override_input;
  // a test or exercise behaves like a utility failure for the engine
  wire need_run = !i_utility_ok || i_test_active;
  wire want_xfer = need_run && i_genset_ok;
  wire post_hold = settings[`CFG_POST_HOLD];
  wire wb_req = i_wb_cyc && i_wb_stb;
  wire [2:0] sel_elev = settings[`CFG_ELEV_LSB +: 3];
  wire home_at_target = to_gen ? i_at_genset : i_at_utility;
  wire target_ok = to_gen ? i_genset_ok : i_utility_ok;
  wire other_ok = to_gen ? i_utility_ok : i_genset_ok;

  //////////////////////////////////////////////////////////////////////
  // timebase and the six delay timers
  tick_divider #(
    .CNT_W(25),
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .o_tick(tick)
  );

  // table lookup of each timer limit from its three-bit selector;
  // a literal cannot be part-selected, so each table is a net first
  wire [127:0] tbl_short = `TBL_SHORT; // half-second steps
  wire [127:0] tbl_minutes = `TBL_MINUTES; // minute steps
  wire [127:0] tbl_long = `TBL_LONG; // transfer and elevator steps
  assign t_limit[T_START*TW +: TW] =
    tbl_short[settings[`CFG_START_LSB +: 3]*16 +: 16];
  assign t_limit[T_COOL*TW +: TW] =
    tbl_minutes[settings[`CFG_COOL_LSB +: 3]*16 +: 16];
  assign t_limit[T_NE*TW +: TW] =
    tbl_long[settings[`CFG_NE_LSB +: 3]*16 +: 16];
  assign t_limit[T_EN*TW +: TW] =
    tbl_minutes[settings[`CFG_EN_LSB +: 3]*16 +: 16];
  assign t_limit[T_PAUSE*TW +: TW] =
    tbl_short[settings[`CFG_PAUSE_LSB +: 3]*16 +: 16];
  assign t_limit[T_ELEV*TW +: TW] =
    tbl_long[sel_elev*16 +: 16];

  genvar gi;
  generate
    for (gi = 0; gi < NT; gi = gi + 1) begin : g_timer
      delay_timer #(
        .W(TW)
      ) u_timer (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_tick(tick),
        .i_clear(t_clear[gi]),
        .i_run(t_run[gi]),
        .i_force(t_force[gi]),
        .i_limit(t_limit[gi*TW +: TW]),
        .o_active(t_active[gi]),
        .o_done(t_done[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // timer control, purely from present state and inputs
  always @* begin
    t_clear = {NT{1'b1}};
    t_run = {NT{1'b0}};
    t_force = {NT{1'b0}};
    // engine start: runs on failure, cleared only when it goes away
    t_clear[T_START] = !need_run;
    t_run[T_START] = need_run;
    t_force[T_START] = override;
    // cooldown: after retransfer, with the engine running; no override
    if (!need_run && !o_start_relay && state == ST_NORMAL &&
        i_at_utility) begin
      t_clear[T_COOL] = 1'b0;
      t_run[T_COOL] = 1'b1;
    end
    // normal to emergency: needs generator; inhibit blocks only a start
    if (state == ST_NORMAL && want_xfer) begin
      t_clear[T_NE] = 1'b0;
      t_run[T_NE] = t_active[T_NE] || !i_transfer_inhibit;
      t_force[T_NE] = override;
    end
    // emergency to normal: generator loss forces expiry if utility is up
    if (state == ST_GENSET && i_utility_ok) begin
      if (!i_genset_ok) begin
        t_clear[T_EN] = 1'b0;
        t_run[T_EN] = 1'b1;
        t_force[T_EN] = 1'b1;
      end else if (!i_test_active) begin
        t_clear[T_EN] = 1'b0;
        t_run[T_EN] = t_active[T_EN] ||
                      !i_retransfer_inhibit;
        t_force[T_EN] = override;
      end
    end
    // neutral pause keeps running whatever the sources do
    if (state == ST_PAUSE) begin
      t_clear[T_PAUSE] = 1'b0;
      t_run[T_PAUSE] = 1'b1;
    end
    // elevator: no inhibit or override term reaches it
    if (state == ST_ELEV_PRE || state == ST_ELEV_POST) begin
      t_clear[T_ELEV] = 1'b0;
      t_run[T_ELEV] = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // engine start relay: energized means stop

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_start_relay <= 1'b1;
    end else if (o_start_relay && t_done[T_START]) begin
      o_start_relay <= 1'b0;
    end else if (!o_start_relay && t_done[T_COOL]) begin
      // energizing drops cooldown's run term, so it clears next edge
      o_start_relay <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // transfer sequencer

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_NORMAL;
      to_gen <= 1'b0;
      live_xfer <= 1'b0;
      o_transfer_cmd <= 1'b0;
      o_retransfer_cmd <= 1'b0;
      o_elevator <= 1'b0;
    end else begin
      case (state)
        ST_NORMAL: begin
          o_elevator <= 1'b0;
          if (i_at_genset && !i_at_utility) begin
            // switch found on generator, e.g. after manual handling
            state <= ST_GENSET;
          end else if (t_done[T_NE]) begin
            to_gen <= 1'b1;
            live_xfer <= i_utility_ok && i_genset_ok;
            // elevator step only between two live sources
            if (sel_elev != 3'h0 && i_utility_ok) begin
              o_elevator <= 1'b1;
              state <= ST_ELEV_PRE;
            end else begin
              o_transfer_cmd <= 1'b1;
              state <= ST_OPEN;
            end
          end
        end
        ST_GENSET: begin
          o_elevator <= 1'b0;
          if (i_at_utility && !i_at_genset) begin
            state <= ST_NORMAL;
          end else if (t_done[T_EN]) begin
            to_gen <= 1'b0;
            live_xfer <= i_utility_ok && i_genset_ok;
            if (sel_elev != 3'h0 && i_genset_ok) begin
              o_elevator <= 1'b1;
              state <= ST_ELEV_PRE;
            end else begin
              o_retransfer_cmd <= 1'b1;
              state <= ST_OPEN;
            end
          end
        end
        ST_ELEV_PRE: begin
          if (t_done[T_ELEV]) begin
            // hold keeps the output up through the whole transfer
            o_elevator <= post_hold;
            o_transfer_cmd <= to_gen;
            o_retransfer_cmd <= !to_gen;
            state <= ST_OPEN;
          end
        end
        ST_OPEN: begin
          if (home_at_target) begin
            // actuator went straight through, nothing to pause for
            o_transfer_cmd <= 1'b0;
            o_retransfer_cmd <= 1'b0;
            state <= (post_hold && o_elevator) ? ST_ELEV_POST :
                     (to_gen ? ST_GENSET : ST_NORMAL);
          end else if (!i_at_utility && !i_at_genset) begin
            // neutral reached: drop the command during the pause
            o_transfer_cmd <= 1'b0;
            o_retransfer_cmd <= 1'b0;
            state <= ST_PAUSE;
          end
        end
        ST_PAUSE: begin
          if (t_done[T_PAUSE]) begin
            // pick whichever source is still live at the end
            if (target_ok) begin
              o_transfer_cmd <= to_gen;
              o_retransfer_cmd <= !to_gen;
              state <= ST_CLOSE;
            end else if (other_ok) begin
              to_gen <= !to_gen;
              o_transfer_cmd <= !to_gen;
              o_retransfer_cmd <= to_gen;
              state <= ST_CLOSE;
            end
          end
        end
        ST_CLOSE: begin
          if (home_at_target) begin
            o_transfer_cmd <= 1'b0;
            o_retransfer_cmd <= 1'b0;
            if (post_hold && o_elevator) begin
              state <= ST_ELEV_POST;
            end else begin
              state <= to_gen ? ST_GENSET : ST_NORMAL;
            end
          end else if (!target_ok && other_ok) begin
            // target died while closing: turn back to the live one
            to_gen <= !to_gen;
            o_transfer_cmd <= !to_gen;
            o_retransfer_cmd <= to_gen;
          end
        end
        ST_ELEV_POST: begin
          if (t_done[T_ELEV]) begin
            o_elevator <= 1'b0;
            state <= to_gen ? ST_GENSET : ST_NORMAL;
          end
        end
        default: begin
          state <= ST_NORMAL;
          o_transfer_cmd <= 1'b0;
          o_retransfer_cmd <= 1'b0;
          o_elevator <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after the request, write on ack

  // ack drops the cycle after it rose, even if the master still holds
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= wb_req && !o_wb_ack;
      if (wb_req && !o_wb_ack) begin
        case (i_wb_adr)
          `ADR_CONFIG: o_wb_dat <= {13'h0000, settings};
          `ADR_STATUS: o_wb_dat <= {17'h0_0000, live_xfer, to_gen, state,
                                   t_done, o_start_relay, o_transfer_cmd,
                                   o_retransfer_cmd, o_elevator};
          default: o_wb_dat <= 32'h0000_0000; // unmapped reads zero
        endcase
      end
    end
  end

  // config write lands on the edge where the master sees ack
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      settings <= `CFG_RESET;
    end else if (wb_req && o_wb_ack && i_wb_we &&
                 i_wb_adr == `ADR_CONFIG) begin
      if (i_wb_sel[0]) begin
        settings[7:0] <= i_wb_dat[7:0];
      end
      if (i_wb_sel[1]) begin
        settings[15:8] <= i_wb_dat[15:8];
      end
      if (i_wb_sel[2]) begin
        settings[18:16] <= i_wb_dat[18:16];
      end
    end
  end

endmodule // transfer_delay_seq

//--- verification/transfer_delay_seq_props.sv
// concurrent checks on the ports of the transfer delay sequencer
`timescale 1ns/10ps
module transfer_delay_seq_props (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  input wire logic i_utility_ok,
  input wire logic i_genset_ok,
  input wire logic i_at_utility,
  input wire logic i_at_genset,
  input wire logic o_start_relay,
  input wire logic o_transfer_cmd,
  input wire logic o_retransfer_cmd,
  input wire logic o_elevator
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  //////////////////////////////////////////////////////////////////////////
  // bus handshake: one registered ack per taken request
  a_ack_one_late:
    assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("request not acknowledged on the next edge");
  a_ack_one_pulse:
    assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  a_ack_needs_req:
    assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without a request");
  //////////////////////////////////////////////////////////////////////////
  // the actuator is never driven both ways; interlock would fight it
  a_cmd_exclusive:
    assert property (!(o_transfer_cmd && o_retransfer_cmd))
    else $error("transfer and retransfer commands together");
  // stop is only sent from utility, after the cooldown there
  a_stop_at_util:
    assert property ($rose(o_start_relay) |->
      $past(i_at_utility) && $past(i_utility_ok))
    else $error("generator stopped away from a live utility");
  // the elevator warning only precedes a live-to-live transfer
  a_elev_live_only:
    assert property ($rose(o_elevator) |->
      $past(i_utility_ok) && $past(i_genset_ok))
    else $error("elevator output raised during a source failure");
  // reaching neutral drops the command so the pause can run
  a_open_drop_fwd:
    assert property (o_transfer_cmd && $fell(i_at_utility) && !i_at_genset
      |-> ##[1:2] !o_transfer_cmd)
    else $error("transfer command kept in neutral");
  a_open_drop_back:
    assert property (o_retransfer_cmd && $fell(i_at_genset) && !i_at_utility
      |-> ##[1:2] !o_retransfer_cmd)
    else $error("retransfer command kept in neutral");
  // commands end once the switch reports the target side
  a_fwd_at_target:
    assert property (o_transfer_cmd && i_at_genset |-> ##[1:2] !o_transfer_cmd)
    else $error("transfer command kept at generator");
  a_back_at_target:
    assert property (o_retransfer_cmd && i_at_utility
      |-> ##[1:2] !o_retransfer_cmd)
    else $error("retransfer command kept at utility");
endmodule // transfer_delay_seq_props

bind transfer_delay_seq transfer_delay_seq_props u_props (
  .i_clock(i_clock),
  .i_rst_n(i_rst_n),
  .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb),
  .o_wb_ack(o_wb_ack),
  .i_utility_ok(i_utility_ok),
  .i_genset_ok(i_genset_ok),
  .i_at_utility(i_at_utility),
  .i_at_genset(i_at_genset),
  .o_start_relay(o_start_relay),
  .o_transfer_cmd(o_transfer_cmd),
  .o_retransfer_cmd(o_retransfer_cmd),
  .o_elevator(o_elevator)
);

//--- verification/genset_actuator_model.sv
// far-side model: generator set and transfer actuator
`timescale 1ns/10ps
module genset_actuator_model #(
  parameter int CRANK = 8,
  parameter int MOVE = 6
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_start_relay,
  input wire logic i_transfer_cmd,
  input wire logic i_retransfer_cmd,
  input wire logic i_fail,
  output logic o_genset_ok,
  output logic o_at_utility,
  output logic o_at_genset
);
  int run_cnt; // clocks since the start contact closed
  int move_cnt; // clocks the actuator has been driven one way
  int pos; // 0 utility, 1 neutral, 2 generator
  //////////////////////////////////////////////////////////////////////////
  // engine cranks, then runs only while the start relay is dropped
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_cnt <= 0;
    end else if (i_start_relay) begin
      run_cnt <= 0;
    end else if (run_cnt < CRANK) begin
      run_cnt <= run_cnt + 1;
    end
  end
  // a forced failure lets the bench kill the source mid-sequence
  assign o_genset_ok = (run_cnt == CRANK) && !i_fail;
  //////////////////////////////////////////////////////////////////////////
  // actuator needs MOVE held clocks per step; dropping the command resets
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pos <= 0;
      move_cnt <= 0;
    end else if (i_transfer_cmd && pos < 2 ||
                 i_retransfer_cmd && pos > 0) begin
      if (move_cnt == MOVE - 1) begin
        pos <= i_transfer_cmd ? pos + 1 : pos - 1;
        move_cnt <= 0;
      end else begin
        move_cnt <= move_cnt + 1;
      end
    end else begin
      move_cnt <= 0;
    end
  end
  assign o_at_utility = (pos == 0);
  assign o_at_genset = (pos == 2);
endmodule // genset_actuator_model

//--- verification/transfer_delay_seq_tb.sv
// self-checking bench for the transfer delay sequencer
`timescale 1ns/10ps
`include "ats_delay_regs.vh"
module transfer_delay_seq_tb;
  localparam int TK = 10; // clocks per 0.1 s tick, shortened for speed
  logic i_clock = 0;
  logic i_rst_n = 0;
  logic cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] o_wb_dat, rd, cfg;
  logic o_wb_ack, o_start_relay, o_transfer_cmd, o_retransfer_cmd, o_elevator;
  logic util = 1, ovr_b = 0, ovr_i = 0, x_inh = 0, r_inh = 0, test = 0;
  logic gfail = 0;
  wire gen_ok, at_u, at_g;
  int err_total = 0;
  int comparisons = 0;
  int n;
  // free-running 250 MHz clock
  always #2 i_clock = ~i_clock;
  transfer_delay_seq #(.TICK_CYCLES(TK)) u_transfer_delay_seq (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_utility_ok(util),
    .i_genset_ok(gen_ok), .i_at_utility(at_u), .i_at_genset(at_g),
    .i_override_button(ovr_b), .i_override_input(ovr_i),
    .i_transfer_inhibit(x_inh), .i_retransfer_inhibit(r_inh),
    .i_test_active(test), .o_start_relay(o_start_relay),
    .o_transfer_cmd(o_transfer_cmd), .o_retransfer_cmd(o_retransfer_cmd),
    .o_elevator(o_elevator));
  genset_actuator_model u_genset_actuator_model (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_start_relay(o_start_relay),
    .i_transfer_cmd(o_transfer_cmd), .i_retransfer_cmd(o_retransfer_cmd),
    .i_fail(gfail), .o_genset_ok(gen_ok), .o_at_utility(at_u),
    .o_at_genset(at_g));
  //////////////////////////////////////////////////////////////////////////
  task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // classic single cycle; a lost ack ends the run
  task automatic wb(logic w, logic [7:0] a, logic [3:0] s, logic [31:0] d,
      output logic [31:0] r);
    int k;
    @(posedge i_clock);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    for (k = 0; k < 20 && o_wb_ack !== 1'b1; k++) @(posedge i_clock);
    if (k == 20) begin
      check("wb ack", 32'h0, 32'h1);
      give_verdict();
    end
    r = o_wb_dat;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  function automatic logic pick(int k);
    case (k)
      0: return o_start_relay;
      1: return o_transfer_cmd;
      2: return o_retransfer_cmd;
      3: return o_elevator;
      4: return gen_ok;
      5: return at_g;
      default: return at_u;
    endcase
  endfunction
  // edges until the watched signal reads v; -1 once the bound runs out
  task automatic wait_for(int k, logic v, int lim, output int cnt);
    cnt = -1;
    for (int j = 1; j <= lim; j++) begin
      @(posedge i_clock);
      if (pick(k) === v) begin
        cnt = j;
        break;
      end
    end
  endtask
  // tick phase is free, so expiry may land up to one tick early
  task automatic timed(string nm, int k, logic v, int t);
    wait_for(k, v, t * TK + 20, n);
    check(nm, 32'(n >= (t - 1) * TK - 2 && n <= t * TK + 6), 32'h1);
    if (n < 0) give_verdict();
  endtask
  // a wait that must succeed; running out of it ends the run
  task automatic reach(int k, logic v, int lim);
    wait_for(k, v, lim, n);
    if (n < 0) begin
      check("wait bound", 32'h0, 32'h1);
      give_verdict();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    rd = $urandom(32'h88ED858F);
    repeat (6) @(posedge i_clock);
    i_rst_n <= 1;
    check("relay at reset", o_start_relay, 32'h1);
    wb(0, `ADR_CONFIG, 4'hF, 32'h0, rd);
    check("config reset", rd, 32'h0000071C);
    wb(0, 8'h10, 4'hF, 32'h0, rd);
    check("unmapped read", rd, 32'h0);
    wb(0, `ADR_STATUS, 4'hF, 32'h0, rd);
    check("status idle", rd, 32'h00000008);
    // random settings read back; a byte-masked write touches one byte
    repeat (3) begin
      cfg = $urandom() & 32'h7FFFF;
      wb(1, `ADR_CONFIG, 4'hF, cfg, rd);
      wb(1, `ADR_CONFIG, 4'h1, ~cfg, rd);
      wb(1, `ADR_STATUS, 4'hF, 32'hFFFFFFFF, rd);
      wb(0, `ADR_CONFIG, 4'hF, 32'h0, rd);
      check("config rw", rd, {cfg[31:8], ~cfg[7:0]});
    end
    // outage: start 0.5 s, cool and e-to-n 0.1 min, n-to-e 1 s, pause 0.5 s
    wb(1, `ADR_CONFIG, 4'hF, 32'h1249, rd);
    util <= 0;
    repeat (20) @(posedge i_clock);
    util <= 1;
    wait_for(0, 0, 80, n);
    check("start after blip", 32'(n), 32'hFFFFFFFF);
    util <= 0;
    timed("start delay", 0, 0, 5);
    reach(4, 1, 40);
    ovr_b <= 1;
    wait_for(1, 1, 6, n);
    check("override n-to-e", 32'(n > 0), 32'h1);
    check("no elevator on failure", o_elevator, 32'h0);
    ovr_b <= 0;
    reach(1, 0, 40);
    timed("neutral pause", 1, 1, 5);
    reach(5, 1, 40);
    r_inh <= 1;
    util <= 1;
    wait_for(2, 1, 700, n);
    check("inhibited retransfer", 32'(n), 32'hFFFFFFFF);
    r_inh <= 0;
    repeat (30) @(posedge i_clock);
    gfail <= 1;
    wait_for(2, 1, 8, n);
    check("genset loss retransfer", 32'(n > 0), 32'h1);
    reach(6, 1, 120);
    gfail <= 0;
    ovr_i <= 1;
    timed("cooldown", 0, 1, 60);
    ovr_i <= 0;
    // test with load, elevator 1 s and post-transfer hold
    wb(1, `ADR_CONFIG, 4'hF, 32'h49249, rd);
    x_inh <= 1;
    test <= 1;
    reach(4, 1, 100);
    wait_for(3, 1, 200, n);
    check("inhibited transfer", 32'(n), 32'hFFFFFFFF);
    x_inh <= 0;
    timed("n-to-e", 3, 1, 10);
    timed("elevator pre", 1, 1, 10);
    reach(5, 1, 120);
    check("hold output", o_elevator, 32'h1);
    timed("elevator post", 3, 0, 10);
    test <= 0;
    timed("e-to-n", 3, 1, 60);
    x_inh <= 1;
    r_inh <= 1;
    ovr_i <= 1;
    timed("elevator ignores", 2, 1, 10);
    x_inh <= 0;
    r_inh <= 0;
    ovr_i <= 0;
    wait_for(0, 1, 1500, n);
    check("stop after test", 32'(n > 0), 32'h1);
    give_verdict();
  end
endmodule // transfer_delay_seq_tb
